// File: design/dlr_pkg.sv
package dlr_pkg;
	// register offsets (byte addresses on the serial bus)
	localparam logic [7:0] RA_AUTO = 8'h06;
	localparam logic [7:0] RA_LOCK_A = 8'h09;
	localparam logic [7:0] RA_LOCK_B = 8'h0a;
	localparam logic [7:0] RA_IRQ_SEL = 8'h0b;
	localparam logic [7:0] RA_TUNER = 8'h0c;
	localparam logic [7:0] RA_ID_HI = 8'h0e;
	localparam logic [7:0] RA_ID_LO = 8'h0f;
	localparam logic [7:0] RA_CLAMP_LO = 8'h13;
	localparam logic [7:0] RA_CLAMP_HI = 8'h14;
	localparam logic [7:0] RA_CTRL = 8'h15;
	localparam logic [7:0] RA_AUX = 8'h17;
	localparam logic [7:0] RA_OVR = 8'h19;
	localparam logic [7:0] RA_BW_CFG0 = 8'h23;
	localparam logic [7:0] RA_BW_CFG1 = 8'h24;
	localparam logic [7:0] RA_BW_NOW = 8'h29;
	localparam logic [7:0] RA_ALPHA_ACQ = 8'h31;
	localparam logic [7:0] RA_BETA_ACQ = 8'h32;
	localparam logic [7:0] RA_ALPHA_FOL = 8'h33;
	localparam logic [7:0] RA_BETA_FOL = 8'h34;
	localparam logic [7:0] RA_SNAP0 = 8'h39;
	localparam logic [7:0] RA_SNAP1 = 8'h3a;
	localparam logic [7:0] RA_SNAP2 = 8'h3b;
	// value that triggers the automatic setup
	localparam logic [7:0] AUTO_CMD = 8'h01;
	// values loaded by reset and by the automatic setup
	localparam logic [7:0] DEF_LOCK_A = 8'h80;
	localparam logic [7:0] DEF_LOCK_B = 8'h70;
	localparam logic [7:0] DEF_IRQ_SEL = 8'h80;
	localparam logic [7:0] DEF_TUNER = 8'h00;
	localparam logic [7:0] DEF_CLAMP_LO = 8'h00;
	localparam logic [7:0] DEF_CLAMP_HI = 8'hff;
	localparam logic [7:0] DEF_CTRL = 8'h00;
	localparam logic [7:0] DEF_AUX = 8'h7f;
	localparam logic [7:0] DEF_BW_CFG0 = 8'h7f;
	localparam logic [7:0] DEF_BW_CFG1 = 8'h90;
	localparam logic [7:0] DEF_ALPHA_ACQ = 8'h7c;
	localparam logic [7:0] DEF_BETA_ACQ = 8'h49;
	localparam logic [7:0] DEF_ALPHA_FOL = 8'h7f;
	localparam logic [7:0] DEF_BETA_FOL = 8'h8e;
	// lock mask bit positions
	localparam int LK_DEC = 7;
	localparam int LK_CAR = 6;
	localparam int LK_EQU = 5;
	localparam int LK_TIM = 4;
	localparam int LK_AGC_A = 3;
	localparam int LK_AGC_D = 2;
	localparam int LK_ADC = 1;
	localparam int LK_PLL = 0;
	// control register bit positions
	localparam int CT_DC_OFF = 5;
	localparam int CT_SIGN = 4;
	localparam int CT_HOLD = 3;
	localparam int CT_DIFF = 1;
	// periodic interrupt selector codes
	localparam logic [1:0] PER_NONE = 2'h0;
	localparam logic [1:0] PER_SHORT = 2'h1;
	localparam logic [1:0] PER_LONG = 2'h2;
	localparam logic [1:0] PER_BITS = 2'h3;
	// periodic and window counts
	localparam int FRAMES_SHORT = 2048;
	localparam int FRAMES_LONG = 16384;
	localparam int BITS_PERIOD = 100000000;
	localparam int OVR_WINDOW = 16384;
	localparam logic [7:0] OVR_MAX = 8'hff;
	// event lines arriving from the core domain
	localparam int EV_SAT = 0;
	localparam int EV_FRM_LOST = 1;
	localparam int EV_FRAME = 2;
	localparam int EV_BIT = 3;
	localparam int EV_ADC_SAT = 4;
	localparam int EV_SAMPLE = 5;
	localparam int EV_TIM_STEP = 6;
	localparam int EV_COUNT = 7;
	// upper five bits of the serial slave address
	localparam logic [4:0] DEV_ADDR_BASE = 5'h0c;
endpackage : dlr_pkg

// File: design/dlr_xing.sv
`timescale 1ns/10ps
// carries lock levels and event pulses from the core clock into clk
module dlr_xing #(
	parameter int LEVELS = 8,
	parameter int PULSES = 7
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic coreClk,
	input wire logic coreResetn,
	input wire logic [LEVELS-1:0] coreLevel,
	input wire logic [PULSES-1:0] corePulse,
	output logic [LEVELS-1:0] level,
	output logic [PULSES-1:0] pulse
);
	// core side: one toggle per event
	typedef struct packed {
		logic [PULSES-1:0] tog;
	} dlr_core_t;
	// clk side: two-flop level sync, three-flop toggle sync
	typedef struct packed {
		logic [LEVELS-1:0] lv1;
		logic [LEVELS-1:0] lv2;
		logic [PULSES-1:0] tg1;
		logic [PULSES-1:0] tg2;
		logic [PULSES-1:0] tg3;
	} dlr_sync_t;
	dlr_core_t c_reg, c_next;
	dlr_sync_t s_reg, s_next;

	// flip toggle on each core pulse
	always_comb begin
		c_next = c_reg;
		c_next.tog = c_reg.tog ^ corePulse;
	end

	always_ff @(posedge coreClk) begin
		if (!coreResetn) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end

	// first flops feed only the second flops
	always_comb begin
		s_next = s_reg;
		s_next.lv1 = coreLevel;
		s_next.lv2 = s_reg.lv1;
		s_next.tg1 = c_reg.tog;
		s_next.tg2 = s_reg.tg1;
		s_next.tg3 = s_reg.tg2;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// one clk pulse per toggle edge
	assign level = s_reg.lv2;
	assign pulse = s_reg.tg2 ^ s_reg.tg3;
endmodule : dlr_xing

// File: design/dlr_pwm.sv
`timescale 1ns/10ps
// free running pulse width generator
module dlr_pwm #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] level,
	output logic pwm
);
	// phase counter and registered output
	typedef struct packed {
		logic [W-1:0] phase;
		logic out;
	} dlr_pwm_t;
	dlr_pwm_t p_reg, p_next;

	// high for level counts out of 2**W
	always_comb begin
		p_next = p_reg;
		p_next.phase = p_reg.phase + 1'b1;
		p_next.out = (p_reg.phase < level);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			p_reg <= '0;
		end else begin
			p_reg <= p_next;
		end
	end

	assign pwm = p_reg.out;
endmodule : dlr_pwm

// File: design/dlr_regs_top.sv
// Behaviour
// - second lock output ANDs its selected locks
// - mask bits map decoder down to synthesizer
// - auto setup loads masks 0x80 and 0x70
// - enabled event asserts irq; write releases it
// - mask 7..4 lock output fall/rise events
// - mask 3 saturation, 2 frame loss
// - mask 1:0 picks periodic interrupt source
// - auto setup enables first-lock-fall only
// - tuner register: address bits, bit0 switch
// - read-only sixteen-bit identifier at two bytes
// - gain command clamped, bounds swap with sign
// - control bit5 dc offset, bit4 sign
// - control bit3 holds converter target level
// - control bit1 selects pwm or differential
// - auxiliary level output as pwm
// - saturations per window, saturating at 255
// - timing bandwidth narrows locked, widens on loss
// - current exponent readable in bits 7:4
// - carrier uses tracking pair once locked
// - auto setup loads carrier coefficient defaults
// - first snapshot byte read latches point
// - polarity input picks asserted irq level
// - first lock output ANDs its selected locks
`timescale 1ns/10ps
module dlr_regs_top #(
	parameter int FRAME_PERIOD_LONG = dlr_pkg::FRAMES_LONG,
	parameter int BIT_PERIOD = dlr_pkg::BITS_PERIOD,
	parameter int OVR_WINDOW = dlr_pkg::OVR_WINDOW,
	parameter logic [15:0] PART_ID = 16'h5a01 // arbitrary identifier value
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [1:0] addrSel,
	input wire logic coreClk,
	input wire logic coreResetn,
	input wire logic [7:0] coreLocks,
	input wire logic [dlr_pkg::EV_COUNT-1:0] coreEvents,
	input wire logic [11:0] constI,
	input wire logic [11:0] constQ,
	input wire logic [7:0] gainCmdRaw,
	input wire logic irqPolarity,
	output logic irqOut,
	output logic irqOe,
	output logic lockOutA,
	output logic lockOutB,
	output logic [6:0] tunerAddr,
	output logic tunerSwitchOn,
	output logic dcCompOn,
	output logic levelHold,
	output logic gainPin,
	output logic auxPin,
	output logic [7:0] carrierAlpha,
	output logic [7:0] carrierBeta,
	output logic [3:0] timingBwExp
);
	// frame counter wide enough for both periodic counts
	localparam int FW = $clog2((FRAME_PERIOD_LONG > dlr_pkg::FRAMES_SHORT)
		? FRAME_PERIOD_LONG : dlr_pkg::FRAMES_SHORT);
	localparam int BW = $clog2(BIT_PERIOD);
	localparam int SW = $clog2(OVR_WINDOW);
	// serial slave states
	typedef enum logic [3:0] {IDLE, ADDR, ACKA, PTR, ACKP, WDATA, ACKW, RDATA, RACK} dlr_bus_t;
	// whole module state
	typedef struct packed {
		logic sclS1, sdaS1, sclS2, sdaS2, sclS3, sdaS3;
		logic [1:0] selS1, selS2;
		dlr_bus_t st;
		logic [3:0] bitCnt;
		logic [7:0] shift, ptr;
		logic rw, nack, oe;
		logic [7:0] lockSelA, lockSelB, irqSel, tuner, clampLo, clampHi;
		logic [7:0] ctrl, aux, bwCfg0, bwCfg1, alphaAcq, betaAcq, alphaFol, betaFol;
		logic [23:0] snap;
		logic irqAct, lockA, lockB;
		logic [FW-1:0] frameCnt;
		logic [BW-1:0] bitsCnt;
		logic [SW-1:0] sampCnt;
		logic [7:0] satCnt, ovrCount, gainCmd, carA, carB;
		logic [3:0] bwNow;
	} dlr_state_t;
	dlr_state_t r_reg, r_next;
	logic [7:0] locks;
	logic [dlr_pkg::EV_COUNT-1:0] ev;
	logic sclRise, sclFall, start, stop, wrStb, rdLoad;
	logic [7:0] rdByte, lo, hi, satNext;
	logic irqHit, perHit, carTrack;
	logic gainPwm, auxPwm;

	// all selected lock signals high
	function automatic logic lockAll(input logic [7:0] l, input logic [7:0] m);
		return &(l | ~m);
	endfunction : lockAll

	// configuration loaded at reset and by the setup command
	function automatic dlr_state_t autoCfg(input dlr_state_t s);
		dlr_state_t t;
		t = s;
		t.lockSelA = dlr_pkg::DEF_LOCK_A;
		t.lockSelB = dlr_pkg::DEF_LOCK_B;
		t.irqSel = dlr_pkg::DEF_IRQ_SEL;
		t.tuner = dlr_pkg::DEF_TUNER;
		t.clampLo = dlr_pkg::DEF_CLAMP_LO;
		t.clampHi = dlr_pkg::DEF_CLAMP_HI;
		t.ctrl = dlr_pkg::DEF_CTRL;
		t.aux = dlr_pkg::DEF_AUX;
		t.bwCfg0 = dlr_pkg::DEF_BW_CFG0;
		t.bwCfg1 = dlr_pkg::DEF_BW_CFG1;
		t.alphaAcq = dlr_pkg::DEF_ALPHA_ACQ;
		t.betaAcq = dlr_pkg::DEF_BETA_ACQ;
		t.alphaFol = dlr_pkg::DEF_ALPHA_FOL;
		t.betaFol = dlr_pkg::DEF_BETA_FOL;
		t.bwNow = dlr_pkg::DEF_BW_CFG0[7:4];
		return t;
	endfunction : autoCfg

	// lock levels and core events into clk
	dlr_xing #(.LEVELS(8), .PULSES(dlr_pkg::EV_COUNT)) uXing (
		.clk(clk),
		.resetn(resetn),
		.coreClk(coreClk),
		.coreResetn(coreResetn),
		.coreLevel(coreLocks),
		.corePulse(coreEvents),
		.level(locks),
		.pulse(ev)
	);

	// bus line edges from synchronised copies
	assign sclRise = r_reg.sclS2 & ~r_reg.sclS3;
	assign sclFall = ~r_reg.sclS2 & r_reg.sclS3;
	assign start = r_reg.sclS2 & r_reg.sclS3 & ~r_reg.sdaS2 & r_reg.sdaS3;
	assign stop = r_reg.sclS2 & r_reg.sclS3 & r_reg.sdaS2 & ~r_reg.sdaS3;

	// identifier and read-only monitors on the read path
	always_comb begin
		case (r_reg.ptr)
			dlr_pkg::RA_LOCK_A: rdByte = r_reg.lockSelA;
			dlr_pkg::RA_LOCK_B: rdByte = r_reg.lockSelB;
			dlr_pkg::RA_IRQ_SEL: rdByte = r_reg.irqSel;
			dlr_pkg::RA_TUNER: rdByte = r_reg.tuner;
			dlr_pkg::RA_ID_HI: rdByte = PART_ID[15:8];
			dlr_pkg::RA_ID_LO: rdByte = PART_ID[7:0];
			dlr_pkg::RA_CLAMP_LO: rdByte = r_reg.clampLo;
			dlr_pkg::RA_CLAMP_HI: rdByte = r_reg.clampHi;
			dlr_pkg::RA_CTRL: rdByte = r_reg.ctrl;
			dlr_pkg::RA_AUX: rdByte = r_reg.aux;
			dlr_pkg::RA_OVR: rdByte = r_reg.ovrCount;
			dlr_pkg::RA_BW_CFG0: rdByte = r_reg.bwCfg0;
			dlr_pkg::RA_BW_CFG1: rdByte = r_reg.bwCfg1;
			dlr_pkg::RA_BW_NOW: rdByte = {r_reg.bwNow, 4'h0};
			dlr_pkg::RA_ALPHA_ACQ: rdByte = r_reg.alphaAcq;
			dlr_pkg::RA_BETA_ACQ: rdByte = r_reg.betaAcq;
			dlr_pkg::RA_ALPHA_FOL: rdByte = r_reg.alphaFol;
			dlr_pkg::RA_BETA_FOL: rdByte = r_reg.betaFol;
			dlr_pkg::RA_SNAP0: rdByte = constI[11:4];
			dlr_pkg::RA_SNAP1: rdByte = r_reg.snap[15:8];
			dlr_pkg::RA_SNAP2: rdByte = r_reg.snap[7:0];
			default: rdByte = 8'h00;
		endcase
	end

	// clamp bounds swap with the amplifier sign
	assign lo = r_reg.ctrl[dlr_pkg::CT_SIGN] ? r_reg.clampHi : r_reg.clampLo;
	assign hi = r_reg.ctrl[dlr_pkg::CT_SIGN] ? r_reg.clampLo : r_reg.clampHi;
	// tracking once gain, equalizer and carrier lock
	assign carTrack = locks[dlr_pkg::LK_AGC_D] & locks[dlr_pkg::LK_EQU] & locks[dlr_pkg::LK_CAR];
	assign satNext = (ev[dlr_pkg::EV_ADC_SAT] && r_reg.satCnt != dlr_pkg::OVR_MAX) ? r_reg.satCnt + 8'h01 : r_reg.satCnt;

	// bus engine, register file and monitors
	always_comb begin
		r_next = r_reg;
		wrStb = 1'b0;
		rdLoad = 1'b0;
		perHit = 1'b0;
		r_next.sclS1 = scl;
		r_next.sdaS1 = sdaIn;
		r_next.sclS2 = r_reg.sclS1;
		r_next.sdaS2 = r_reg.sdaS1;
		r_next.sclS3 = r_reg.sclS2;
		r_next.sdaS3 = r_reg.sdaS2;
		r_next.selS1 = addrSel;
		r_next.selS2 = r_reg.selS1;
		// bit sampling on rising clock
		if (sclRise) begin
			if (r_reg.st == RACK) begin
				r_next.nack = r_reg.sdaS2;
			end else if (r_reg.st == ADDR || r_reg.st == PTR || r_reg.st == WDATA || r_reg.st == RDATA) begin
				r_next.shift = {r_reg.shift[6:0], r_reg.sdaS2};
				r_next.bitCnt = r_reg.bitCnt + 4'h1;
			end
		end
		// state moves on falling clock
		if (sclFall) begin
			case (r_reg.st)
				ADDR: begin
					if (r_reg.bitCnt == 4'h8) begin
						if (r_reg.shift[7:1] == {dlr_pkg::DEV_ADDR_BASE, r_reg.selS2}) begin
							r_next.st = ACKA;
							r_next.rw = r_reg.shift[0];
							r_next.oe = 1'b1;
						end else begin
							r_next.st = IDLE;
						end
					end
				end
				PTR: begin
					if (r_reg.bitCnt == 4'h8) begin
						r_next.ptr = r_reg.shift;
						r_next.st = ACKP;
						r_next.oe = 1'b1;
					end
				end
				WDATA: begin
					if (r_reg.bitCnt == 4'h8) begin
						wrStb = 1'b1;
						r_next.st = ACKW;
						r_next.oe = 1'b1;
					end
				end
				ACKA: begin
					r_next.bitCnt = 4'h0;
					r_next.oe = 1'b0;
					if (r_reg.rw) begin
						rdLoad = 1'b1;
					end else begin
						r_next.st = PTR;
					end
				end
				ACKP, ACKW: begin
					r_next.bitCnt = 4'h0;
					r_next.oe = 1'b0;
					r_next.st = WDATA;
				end
				RDATA: begin
					if (r_reg.bitCnt == 4'h8) begin
						r_next.oe = 1'b0;
						r_next.st = RACK;
					end else begin
						r_next.oe = ~r_reg.shift[7];
					end
				end
				RACK: begin
					r_next.bitCnt = 4'h0;
					if (r_reg.nack) begin
						r_next.st = IDLE;
					end else begin
						rdLoad = 1'b1;
					end
				end
				default: r_next.st = r_reg.st;
			endcase
		end
		// reading the first snapshot byte latches the point
		if (rdLoad) begin
			r_next.st = RDATA;
			r_next.shift = rdByte;
			r_next.oe = ~rdByte[7];
			r_next.ptr = r_reg.ptr + 8'h01;
			if (r_reg.ptr == dlr_pkg::RA_SNAP0) begin
				r_next.snap = {constI[11:4], constQ[11:4], constI[3:0], constQ[3:0]};
			end
		end
		// register writes; read-only and unmapped bytes ignored
		if (wrStb) begin
			r_next.ptr = r_reg.ptr + 8'h01;
			case (r_reg.ptr)
				dlr_pkg::RA_AUTO: begin
					if (r_reg.shift == dlr_pkg::AUTO_CMD) begin
						r_next = autoCfg(r_next);
					end
				end
				dlr_pkg::RA_LOCK_A: r_next.lockSelA = r_reg.shift;
				dlr_pkg::RA_LOCK_B: r_next.lockSelB = r_reg.shift;
				dlr_pkg::RA_IRQ_SEL: r_next.irqSel = r_reg.shift;
				dlr_pkg::RA_TUNER: r_next.tuner = r_reg.shift;
				dlr_pkg::RA_CLAMP_LO: r_next.clampLo = r_reg.shift;
				dlr_pkg::RA_CLAMP_HI: r_next.clampHi = r_reg.shift;
				dlr_pkg::RA_CTRL: r_next.ctrl = r_reg.shift;
				dlr_pkg::RA_AUX: r_next.aux = r_reg.shift;
				dlr_pkg::RA_BW_CFG0: r_next.bwCfg0 = r_reg.shift;
				dlr_pkg::RA_BW_CFG1: r_next.bwCfg1 = r_reg.shift;
				dlr_pkg::RA_ALPHA_ACQ: r_next.alphaAcq = r_reg.shift;
				dlr_pkg::RA_BETA_ACQ: r_next.betaAcq = r_reg.shift;
				dlr_pkg::RA_ALPHA_FOL: r_next.alphaFol = r_reg.shift;
				dlr_pkg::RA_BETA_FOL: r_next.betaFol = r_reg.shift;
				default: r_next.ptr = r_reg.ptr + 8'h01;
			endcase
		end
		// start and stop override the byte engine
		if (start) begin
			r_next.st = ADDR;
			r_next.bitCnt = 4'h0;
			r_next.oe = 1'b0;
		end else if (stop) begin
			r_next.st = IDLE;
			r_next.oe = 1'b0;
		end
		r_next.lockA = lockAll(locks, r_reg.lockSelA);
		r_next.lockB = lockAll(locks, r_reg.lockSelB);
		// periodic source by frames or received bits
		if (ev[dlr_pkg::EV_FRAME]) begin
			// short mode wraps at its own count, other modes at the long one
			if ((r_reg.irqSel[1:0] == dlr_pkg::PER_SHORT) ? (r_reg.frameCnt == FW'(dlr_pkg::FRAMES_SHORT - 1))
					: (r_reg.frameCnt == FW'(FRAME_PERIOD_LONG - 1))) begin
				r_next.frameCnt = '0;
				perHit = (r_reg.irqSel[1:0] == dlr_pkg::PER_SHORT) || (r_reg.irqSel[1:0] == dlr_pkg::PER_LONG);
			end else begin
				r_next.frameCnt = r_reg.frameCnt + 1'b1;
			end
		end
		if (ev[dlr_pkg::EV_BIT]) begin
			if (r_reg.bitsCnt == BW'(BIT_PERIOD - 1)) begin
				r_next.bitsCnt = '0;
				perHit = perHit | (r_reg.irqSel[1:0] == dlr_pkg::PER_BITS);
			end else begin
				r_next.bitsCnt = r_reg.bitsCnt + 1'b1;
			end
		end
		irqHit = (r_reg.irqSel[7] & r_reg.lockA & ~r_next.lockA) | (r_reg.irqSel[6] & ~r_reg.lockA & r_next.lockA)
			| (r_reg.irqSel[5] & r_reg.lockB & ~r_next.lockB) | (r_reg.irqSel[4] & ~r_reg.lockB & r_next.lockB)
			| (r_reg.irqSel[3] & ev[dlr_pkg::EV_SAT]) | (r_reg.irqSel[2] & ev[dlr_pkg::EV_FRM_LOST]) | perHit;
		// any write releases, a new event wins
		r_next.irqAct = irqHit | (r_reg.irqAct & ~wrStb);
		if (ev[dlr_pkg::EV_SAMPLE]) begin
			if (r_reg.sampCnt == SW'(OVR_WINDOW - 1)) begin
				r_next.sampCnt = '0;
				r_next.ovrCount = satNext;
				r_next.satCnt = 8'h00;
			end else begin
				r_next.sampCnt = r_reg.sampCnt + 1'b1;
				r_next.satCnt = satNext;
			end
		end else begin
			r_next.satCnt = satNext;
		end
		// bandwidth narrows while locked, widens on loss
		if (r_reg.bwNow < r_reg.bwCfg0[7:4] || r_reg.bwNow > r_reg.bwCfg0[3:0] || !locks[dlr_pkg::LK_TIM]) begin
			r_next.bwNow = r_reg.bwCfg0[7:4];
		end else if (ev[dlr_pkg::EV_TIM_STEP] && r_reg.bwNow < r_reg.bwCfg0[3:0]) begin
			r_next.bwNow = r_reg.bwNow + 4'h1;
		end
		r_next.gainCmd = (gainCmdRaw < lo) ? lo : ((gainCmdRaw > hi) ? hi : gainCmdRaw);
		r_next.carA = carTrack ? r_reg.alphaFol : r_reg.alphaAcq;
		r_next.carB = carTrack ? r_reg.betaFol : r_reg.betaAcq;
	end

	// state register, reset applies the automatic setup
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r_reg <= autoCfg('0);
		end else begin
			r_reg <= r_next;
		end
	end

	dlr_pwm #(.W(8)) uGainPwm (.clk(clk), .resetn(resetn), .level(r_reg.gainCmd), .pwm(gainPwm));
	dlr_pwm #(.W(8)) uAuxPwm (.clk(clk), .resetn(resetn), .level(r_reg.aux), .pwm(auxPwm));

	// outputs
	assign sdaOut = 1'b0;
	assign sdaOe = r_reg.oe;
	// asserted level follows polarity, else released
	assign irqOut = irqPolarity;
	assign irqOe = r_reg.irqAct;
	assign lockOutA = r_reg.lockA;
	assign lockOutB = r_reg.lockB;
	assign tunerAddr = r_reg.tuner[7:1];
	assign tunerSwitchOn = r_reg.tuner[0];
	assign dcCompOn = ~r_reg.ctrl[dlr_pkg::CT_DC_OFF];
	assign levelHold = r_reg.ctrl[dlr_pkg::CT_HOLD];
	assign gainPin = gainPwm;
	assign auxPin = r_reg.ctrl[dlr_pkg::CT_DIFF] ? ~gainPwm : auxPwm;
	assign carrierAlpha = r_reg.carA;
	assign carrierBeta = r_reg.carB;
	assign timingBwExp = r_reg.bwNow;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence sAutoWr;
		wrStb && r_reg.ptr == dlr_pkg::RA_AUTO && r_reg.shift == dlr_pkg::AUTO_CMD;
	endsequence
	sequence sSnapRead;
		rdLoad && r_reg.ptr == dlr_pkg::RA_SNAP0;
	endsequence
	AST_LOCK_B: assert property (lockOutB == $past(lockAll(locks, r_reg.lockSelB)))
		else $error("second lock output wrong");
	AST_LOCK_A: assert property (##1 lockOutA == $past(&(locks | ~r_reg.lockSelA)))
		else $error("first lock output wrong");
	AST_AUTO_MASK: assert property (sAutoWr |=> r_reg.lockSelA == 8'h80 && r_reg.lockSelB == 8'h70)
		else $error("setup masks wrong");
	AST_AUTO_IRQ: assert property (sAutoWr |=> r_reg.irqSel == 8'h80)
		else $error("setup irq mask wrong");
	AST_AUTO_CAR: assert property (sAutoWr |=> r_reg.alphaAcq == 8'h7c && r_reg.betaFol == 8'h8e)
		else $error("setup carrier values wrong");
	AST_IRQ_SET: assert property (irqHit |=> irqOe [*1] ##0 irqOut == irqPolarity)
		else $error("irq not raised");
	AST_IRQ_CLR: assert property (wrStb && !irqHit |=> !irqOe)
		else $error("irq not released by write");
	AST_SNAP_HOLD: assert property (!(rdLoad && r_reg.ptr == dlr_pkg::RA_SNAP0) |=> $stable(r_reg.snap))
		else $error("snapshot changed without read");
	AST_SNAP_LOAD: assert property (sSnapRead |=> r_reg.snap == $past({constI[11:4], constQ[11:4], constI[3:0], constQ[3:0]}))
		else $error("snapshot not latched on first byte");
	AST_CLAMP: assert property (##1 r_reg.gainCmd >= $past(lo) && r_reg.gainCmd <= $past(hi) || $past(lo) > $past(hi))
		else $error("gain out of clamp");
	AST_DIFF: assert property (r_reg.ctrl[dlr_pkg::CT_DIFF] |-> auxPin != gainPin)
		else $error("differential output wrong");
	AST_BW_LOSS: assert property (!locks[dlr_pkg::LK_TIM] |=> timingBwExp == $past(r_reg.bwCfg0[7:4]))
		else $error("bandwidth not widened on loss");
	AST_CAR_SEL: assert property (!carTrack |=> carrierAlpha == $past(r_reg.alphaAcq))
		else $error("carrier pair wrong");
endmodule : dlr_regs_top

// File: verif/dlr_host.sv
`timescale 1ns/10ps
// bus master on the register bus, open drain data with pull-up
module dlr_host (
	input wire logic clk,
	input wire logic sdaOe,
	output logic scl,
	output logic sda
);
	logic pull; // master pulls data low
	// wired line, high when both released
	assign sda = ~(pull | sdaOe);
	// idle bus at time zero
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// set both lines, hold a quarter bit
	task automatic ph(input logic p, input logic c);
		pull = p;
		scl = c;
		repeat (10) @(posedge clk);
		#1;
	endtask : ph
	// byte msb first plus ninth bit, sampled with scl high
	task automatic by(input logic [7:0] d, input logic ak, output logic [7:0] r);
		logic [8:0] v;
		logic [8:0] s;
		v = {d, ak};
		for (int i = 8; i >= 0; i--) begin
			ph(~v[i], 1'b0);
			ph(~v[i], 1'b1);
			s[i] = sda;
			ph(~v[i], 1'b1);
			ph(~v[i], 1'b0);
		end
		r = s[8:1];
	endtask : by
	// start, also repeated
	task automatic st();
		ph(1'b0, 1'b0);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask : st
	// stop, bus back to idle
	task automatic sp();
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
	endtask : sp
	// write one register
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		st();
		by({dlr_pkg::DEV_ADDR_BASE, 3'h0}, 1'b1, r);
		by(a, 1'b1, r);
		by(d, 1'b1, r);
		sp();
	endtask : wr
	// read one register, master nack ends it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		st();
		by({dlr_pkg::DEV_ADDR_BASE, 3'h0}, 1'b1, d);
		by(a, 1'b1, d);
		st();
		by({dlr_pkg::DEV_ADDR_BASE, 3'h1}, 1'b1, d);
		by(8'hff, 1'b1, d);
		sp();
	endtask : rd
endmodule : dlr_host

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam logic [15:0] ID = 16'h3c96; // arbitrary identifier value
	logic clk = 1'b0;
	logic coreClk = 1'b0;
	logic resetn = 1'b0;
	logic irqPolarity = 1'b0;
	logic scl, sda, sdaOe, irqOut, irqOe, lockOutA, lockOutB, tunerSwitchOn, dcCompOn, levelHold;
	logic [7:0] coreLocks = 8'h00;
	logic gainPin, auxPin;
	logic [6:0] coreEvents = 7'h00;
	logic [7:0] rv, m, carrierAlpha, carrierBeta;
	logic [11:0] constI = 12'h000;
	logic [11:0] constQ = 12'h000;
	logic [11:0] si, sq;
	logic [6:0] tunerAddr;
	logic [3:0] timingBwExp;
	int fail_count = 0;
	int cmp_count = 0;
	// offsets and their reset values, first three writable
	logic [7:0] ra [18] = '{8'h13, 8'h17, 8'h31, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h14, 8'h15,
		8'h23, 8'h24, 8'h32, 8'h33, 8'h34, 8'h0e, 8'h0f, 8'h29, 8'h10};
	logic [7:0] rd [18] = '{8'h00, 8'h7f, 8'h7c, 8'h80, 8'h70, 8'h80, 8'h00, 8'hff, 8'h00,
		8'h7f, 8'h90, 8'h49, 8'h7f, 8'h8e, ID[15:8], ID[7:0], 8'h70, 8'h00};
	// clocks, core one unrelated at 80 ns
	always #5 clk = ~clk;
	always #40 coreClk = ~coreClk;
	dlr_host dlr_host_inst (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));
	dlr_regs_top #(.FRAME_PERIOD_LONG(16), .BIT_PERIOD(32), .OVR_WINDOW(16), .PART_ID(ID)) dlr_regs_top_inst (
		.clk(clk), .resetn(resetn), .scl(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .addrSel(2'h0),
		.coreClk(coreClk), .coreResetn(resetn), .coreLocks(coreLocks), .coreEvents(coreEvents), .constI(constI),
		.constQ(constQ), .gainCmdRaw(constI[11:4]), .irqPolarity(irqPolarity), .irqOut(irqOut), .irqOe(irqOe),
		.lockOutA(lockOutA), .lockOutB(lockOutB), .tunerAddr(tunerAddr), .tunerSwitchOn(tunerSwitchOn),
		.dcCompOn(dcCompOn), .levelHold(levelHold), .gainPin(gainPin), .auxPin(auxPin),
		.carrierAlpha(carrierAlpha), .carrierBeta(carrierBeta), .timingBwExp(timingBwExp));
	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// compare one value
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// read a register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		dlr_host_inst.rd(a, rv);
		chk("register", e, rv);
	endtask : rchk
	// let lock levels cross and settle
	task automatic w20();
		repeat (20) @(posedge clk);
		#1;
	endtask : w20
	// hold core event lines for n core clock cycles
	task automatic evp(input logic [6:0] e, input int n);
		@(posedge coreClk);
		#1;
		coreEvents = e;
		repeat (n) @(posedge coreClk);
		#1;
		coreEvents = 7'h00;
		w20();
	endtask : evp
	// expected lock output for a mask
	function automatic logic lk(input logic [7:0] msk, input logic [7:0] l);
		return &(l | ~msk);
	endfunction : lk
	// hang guard
	initial begin
		repeat (99000) @(posedge clk);
		fail_count++;
		close_out();
	end
	// main sequence
	initial begin
		void'($urandom(28));
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		w20();
		foreach (ra[i]) begin
			rchk(ra[i], rd[i]);
		end
		for (int i = 0; i < 3; i++) begin
			m = 8'($urandom());
			dlr_host_inst.wr(ra[i], m);
			rchk(ra[i], m);
		end
		dlr_host_inst.wr(8'h0e, 8'h00);
		rchk(8'h0e, ID[15:8]);
		dlr_host_inst.wr(8'h06, 8'h01);
		rchk(8'h31, 8'h7c);
		// random masks and lock levels
		for (int i = 0; i < 6; i++) begin
			m = (i == 0) ? 8'h00 : 8'($urandom());
			dlr_host_inst.wr(8'h0a, m);
			coreLocks = (i == 1) ? 8'hff : 8'($urandom());
			constI = 12'($urandom());
			w20();
			chk("lockB", 8'(lk(m, coreLocks)), 8'(lockOutB));
			chk("lockA", 8'(lk(8'h80, coreLocks)), 8'(lockOutA));
			chk("alpha", (coreLocks[6] & coreLocks[5] & coreLocks[2]) ? 8'h7f : 8'h7c, carrierAlpha);
			chk("beta", (coreLocks[6] & coreLocks[5] & coreLocks[2]) ? 8'h8e : 8'h49, carrierBeta);
			chk("bw", 8'h07, 8'(timingBwExp));
		end
		// lock b rising raises the interrupt
		irqPolarity = 1'($urandom());
		coreLocks = 8'h00;
		dlr_host_inst.wr(8'h0a, 8'h01);
		dlr_host_inst.wr(8'h0b, 8'h10);
		w20();
		chk("irqIdle", 8'h00, 8'(irqOe));
		coreLocks = 8'h01;
		for (int i = 0; i < 40 && irqOe !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (irqOe !== 1'b1) begin
			fail_count++;
			close_out();
		end
		chk("irqOn", 8'h01, 8'(irqOe));
		chk("irqLevel", 8'(irqPolarity), 8'(irqOut));
		// switch closed only while tuning
		m = {7'($urandom()), 1'b1};
		dlr_host_inst.wr(8'h0c, m);
		chk("irqOff", 8'h00, 8'(irqOe));
		chk("tuner", m, {tunerAddr, tunerSwitchOn});
		dlr_host_inst.wr(8'h0c, 8'h00);
		chk("switch", 8'h00, 8'(tunerSwitchOn));
		// masked event stays quiet
		dlr_host_inst.wr(8'h0b, 8'h00);
		coreLocks = 8'h00;
		w20();
		chk("irqMasked", 8'h00, 8'(irqOe));
		// control bits, reserved bits zero
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 8'h2a : 8'h00;
			dlr_host_inst.wr(8'h15, m);
			chk("dcComp", {7'h00, ~m[5]}, 8'(dcCompOn));
			chk("hold", 8'(m[3]), 8'(levelHold));
			if (m[1]) begin
				chk("diff", 8'h01, 8'(auxPin ^ gainPin));
			end
		end
		// core events: saturation, periodic frames, overrange window
		dlr_host_inst.wr(8'h0b, 8'h08);
		evp(7'h01, 1);
		chk("irqSat", 8'h01, 8'(irqOe));
		dlr_host_inst.wr(8'h0b, 8'h02);
		evp(7'h34, 15);
		chk("irqEarly", 8'h00, 8'(irqOe));
		evp(7'h34, 1);
		chk("irqPer", 8'h01, 8'(irqOe));
		rchk(8'h19, 8'h10);
		// timing bandwidth narrows to its minimum, widens on loss
		dlr_host_inst.wr(8'h23, 8'h7c);
		coreLocks = 8'h10;
		evp(7'h40, 8);
		chk("bwMin", 8'h0c, 8'(timingBwExp));
		rchk(8'h29, 8'hc0);
		coreLocks = 8'h00;
		w20();
		chk("bwLoss", 8'h07, 8'(timingBwExp));
		// snapshot held until first byte read again
		constQ = 12'($urandom());
		rchk(8'h39, constI[11:4]);
		si = constI;
		sq = constQ;
		constI = ~si;
		constQ = ~sq;
		rchk(8'h3a, sq[11:4]);
		rchk(8'h3b, {si[3:0], sq[3:0]});
		close_out();
	end
endmodule : testbench
